// file: src/screen_status_defines.svh
`ifndef SCREEN_STATUS_DEFINES_SVH
`define SCREEN_STATUS_DEFINES_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_CONFIG 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_STATUS 8'h08
`define OFS_IRQ_CLEAR 8'h0C
`define OFS_IRQ_ENABLE 8'h10
`define OFS_FAULT 8'h14
// ----------------------------------------
// Config fields and reset values
// ----------------------------------------
`define CFG_MANUAL_BIT 0
`define CFG_FEEDBACK_LSB 1
`define CFG_COARSE_BIT 3
`define CFG_SELECT_BIT 4
`define CFG_RESET_VAL 8'h02
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 40000000
`define FLASH_MS 250
`define FLASH_CYC ((`CLK_HZ / 1000) * `FLASH_MS)
`define SELFTEST_MS 1000
`define SELFTEST_CYC ((`CLK_HZ / 1000) * `SELFTEST_MS)
`define SHOWCODE_MS 1000
`define SHOWCODE_CYC ((`CLK_HZ / 1000) * `SHOWCODE_MS)
`define RESET_MIN_MS 100
`define RESET_MIN_CYC ((`CLK_HZ / 1000) * `RESET_MIN_MS)
`define RESET_MAX_MS 2000
`define RESET_MAX_CYC ((`CLK_HZ / 1000) * `RESET_MAX_MS)
`endif

// file: src/screen_status_pkg.sv
package screen_status_pkg;
    // ----------------------------------------
    // System states
    // ----------------------------------------
    typedef enum logic [2:0]
    {
        ST_SELFTEST,
        ST_SHOWCODE,
        ST_LOCKOUT,
        ST_TEST,
        ST_LATCH,
        ST_CLEAR,
        ST_BLOCKED
    } sys_state_t;
    // Bicolour lamp drive
    typedef struct packed
    {
        logic red;
        logic green;
    } lamp_t;
    // Interrupt event layout
    typedef struct packed
    {
        logic reset_taken;
        logic lockout;
        logic cleared;
        logic blocked;
    } events_t;
endpackage : screen_status_pkg

// file: src/light_screen_status_logic.sv
// The implementer's own choices: the plain strobed port and the placing of the registers.
`include "screen_status_defines.svh"
// Overview of operation
// - Fault halt: status single-flashes red, zone and reset lamps dark.
// - Emitter in normal operation shows steady green status.
// - Emitter test input open: test mode, status flashes green.
// - Manual restart, beams clear, no reset: red status, reset double-flash, zones green.
// - Manual restart: outputs on only when all clear and after valid reset.
// - Clear state: status green or flashing green with coarse mode, reset yellow.
// - Blocked: red status, yellow reset, blocked zones red, blocked count displayed.
// - First beam blocked: zone one red, every other zone off.
// - Sync comes from beam one; its loss stops evaluating other beams.
// - Test input open: display total beams minus one, all zones red.
// - Defaults: auto restart, two-channel feedback, coarse off, select code one.
// - Power-up flashes all indicators then shows the select code.
// - Auto restart: status red for as long as any beam is interrupted.
module light_screen_status_logic #(
    parameter int BEAMS = 16,
    parameter int ZONES = 8,
    parameter int FLASH_CYC = `FLASH_CYC,
    parameter int SELFTEST_CYC = `SELFTEST_CYC,
    parameter int SHOWCODE_CYC = `SHOWCODE_CYC,
    parameter int RESET_MIN_CYC = `RESET_MIN_CYC,
    parameter int RESET_MAX_CYC = `RESET_MAX_CYC
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [BEAMS-1:0] BEAM_BLOCKED,
    input wire logic FAULT,
    input wire logic TEST_OPEN,
    input wire logic RESET_SWITCH,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output screen_status_pkg::lamp_t RX_STATUS_LAMP,
    output screen_status_pkg::lamp_t TX_STATUS_LAMP,
    output logic RESET_LAMP,
    output screen_status_pkg::lamp_t [ZONES-1:0] ZONE_LAMP,
    output logic [11:0] DISPLAY,
    output logic [1:0] SAFETY_OUTPUT_PAIR,
    output logic IRQ
);
    localparam int BPZ = BEAMS / ZONES;
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [2:0] tst_s_r, rst_s_r;
    logic tst_r, rsw_r;
    // Three stages; a change counts only when stages two and three agree
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            tst_s_r <= 3'h0;
            rst_s_r <= 3'h0;
            tst_r <= 1'b0;
            rsw_r <= 1'b0;
        end
        else
        begin
            tst_s_r <= {tst_s_r[1:0], TEST_OPEN};
            rst_s_r <= {rst_s_r[1:0], RESET_SWITCH};
            if (tst_s_r[1] == tst_s_r[2])
                tst_r <= tst_s_r[2];
            if (rst_s_r[1] == rst_s_r[2])
                rsw_r <= rst_s_r[2];
        end
    end
    // ----------------------------------------
    // Configuration and registers
    // ----------------------------------------
    logic [7:0] cfg_r;
    logic [3:0] irq_en_r;
    screen_status_pkg::events_t irq_st_r, ev;
    logic clr_wr;
    assign clr_wr = WR && ADDR == `OFS_IRQ_CLEAR;
    // Config resets to auto restart, two-channel feedback, coarse off, code one
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            cfg_r <= `CFG_RESET_VAL;
        else if (WR && ADDR == `OFS_CONFIG)
            cfg_r <= WDATA[7:0];
    end
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            irq_en_r <= 4'h0;
        else if (WR && ADDR == `OFS_IRQ_ENABLE)
            irq_en_r <= WDATA[3:0];
    end
    // Set wins over a clear in the same cycle
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            irq_st_r <= '0;
        else
            irq_st_r <= (irq_st_r & ~(clr_wr ? WDATA[3:0] : 4'h0)) | ev;
    end
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            IRQ <= 1'b0;
        else
            IRQ <= |(irq_st_r & irq_en_r);
    end
    // ----------------------------------------
    // Beam evaluation
    // ----------------------------------------
    // Without beam one there is no sync, so the rest cannot be judged
    function automatic logic [BEAMS-1:0] seen(input logic [BEAMS-1:0] b);
        seen = b[0] ? {{(BEAMS-1){1'b0}}, 1'b1} : b;
    endfunction : seen
    function automatic logic [11:0] popcount(input logic [BEAMS-1:0] b);
        popcount = 12'h000;
        for (int i = 0; i < BEAMS; i++)
            popcount = popcount + 12'(b[i]);
    endfunction : popcount
    logic [BEAMS-1:0] eff;
    logic any_blk;
    assign eff = seen(BEAM_BLOCKED);
    assign any_blk = |eff;
    // ----------------------------------------
    // State machine and reset qualification
    // ----------------------------------------
    screen_status_pkg::sys_state_t st_r, st_nxt;
    logic [31:0] tmr_r, rhold_r;
    logic rsw_d_r, reset_ok;
    // Operator holds at least a tenth of a second, never beyond two seconds
    assign reset_ok = rsw_d_r && !rsw_r && rhold_r >= 32'(RESET_MIN_CYC)
                      && rhold_r <= 32'(RESET_MAX_CYC);
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            rsw_d_r <= 1'b0;
            rhold_r <= 32'h0;
        end
        else
        begin
            rsw_d_r <= rsw_r;
            rhold_r <= rsw_r ? rhold_r + 32'h1 : 32'h0;
        end
    end
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            screen_status_pkg::ST_SELFTEST:
                if (tmr_r >= 32'(SELFTEST_CYC - 1))
                    st_nxt = screen_status_pkg::ST_SHOWCODE;
            screen_status_pkg::ST_SHOWCODE:
                if (tmr_r >= 32'(SHOWCODE_CYC - 1))
                    st_nxt = screen_status_pkg::ST_BLOCKED;
            screen_status_pkg::ST_LOCKOUT:
                st_nxt = screen_status_pkg::ST_LOCKOUT;
            screen_status_pkg::ST_TEST:
                if (!tst_r)
                    st_nxt = screen_status_pkg::ST_BLOCKED;
            screen_status_pkg::ST_LATCH:
                if (any_blk)
                    st_nxt = screen_status_pkg::ST_BLOCKED;
                else if (reset_ok)
                    st_nxt = screen_status_pkg::ST_CLEAR;
            screen_status_pkg::ST_CLEAR:
                if (any_blk)
                    st_nxt = screen_status_pkg::ST_BLOCKED;
            screen_status_pkg::ST_BLOCKED:
                if (!any_blk)
                    st_nxt = cfg_r[`CFG_MANUAL_BIT] ? screen_status_pkg::ST_LATCH
                                                    : screen_status_pkg::ST_CLEAR;
            default:
                st_nxt = screen_status_pkg::ST_LOCKOUT;
        endcase
        // Past self-test and code display, fault overrides all; test mode overrides beam results
        if (st_r != screen_status_pkg::ST_SELFTEST && st_r != screen_status_pkg::ST_SHOWCODE)
        begin
            if (FAULT)
                st_nxt = screen_status_pkg::ST_LOCKOUT;
            else if (tst_r && st_r != screen_status_pkg::ST_LOCKOUT)
                st_nxt = screen_status_pkg::ST_TEST;
        end
    end
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            st_r <= screen_status_pkg::ST_SELFTEST;
            tmr_r <= 32'h0;
        end
        else
        begin
            st_r <= st_nxt;
            tmr_r <= (st_nxt != st_r) ? 32'h0 : tmr_r + 32'h1;
        end
    end
    assign ev.blocked = st_nxt == screen_status_pkg::ST_BLOCKED
                        && st_r != screen_status_pkg::ST_BLOCKED;
    assign ev.cleared = st_nxt == screen_status_pkg::ST_CLEAR
                        && st_r != screen_status_pkg::ST_CLEAR;
    assign ev.lockout = st_nxt == screen_status_pkg::ST_LOCKOUT
                        && st_r != screen_status_pkg::ST_LOCKOUT;
    assign ev.reset_taken = reset_ok && st_r == screen_status_pkg::ST_LATCH && !any_blk;
    // ----------------------------------------
    // Flash pattern timing
    // ----------------------------------------
    logic [31:0] ftmr_r;
    logic [1:0] phase_r;
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            ftmr_r <= 32'h0;
            phase_r <= 2'h0;
        end
        else if (ftmr_r >= 32'(FLASH_CYC - 1))
        begin
            ftmr_r <= 32'h0;
            phase_r <= phase_r + 2'h1;
        end
        else
            ftmr_r <= ftmr_r + 32'h1;
    end
    logic single_f, double_f, blink_f;
    assign single_f = phase_r == 2'h0; // One pulse per four phases
    // Two short pulses in every four phases
    assign double_f = (phase_r == 2'h0) || (phase_r == 2'h2);
    assign blink_f = phase_r[0];
    // ----------------------------------------
    // Indicator and output drive
    // ----------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            RX_STATUS_LAMP <= '0;
            TX_STATUS_LAMP <= '0;
            RESET_LAMP <= 1'b0;
            ZONE_LAMP <= '0;
            DISPLAY <= 12'h000;
            SAFETY_OUTPUT_PAIR <= 2'h0;
        end
        else
        begin
            TX_STATUS_LAMP <= '{red: 1'b0, green: 1'b1};
            SAFETY_OUTPUT_PAIR <= 2'h0;
            case (st_r)
                screen_status_pkg::ST_SELFTEST:
                begin
                    RX_STATUS_LAMP <= {blink_f, blink_f};
                    TX_STATUS_LAMP <= {blink_f, blink_f};
                    RESET_LAMP <= blink_f;
                    ZONE_LAMP <= {ZONES{blink_f, blink_f}};
                    DISPLAY <= 12'hFFF;
                end
                screen_status_pkg::ST_SHOWCODE:
                begin
                    RX_STATUS_LAMP <= '0;
                    RESET_LAMP <= 1'b0;
                    ZONE_LAMP <= '0;
                    DISPLAY <= 12'(cfg_r[`CFG_SELECT_BIT]) + 12'h001;
                end
                screen_status_pkg::ST_LOCKOUT:
                begin
                    RX_STATUS_LAMP <= '{red: single_f, green: 1'b0};
                    TX_STATUS_LAMP <= '{red: single_f, green: 1'b0};
                    RESET_LAMP <= 1'b0;
                    ZONE_LAMP <= '0;
                    DISPLAY <= 12'h000;
                end
                screen_status_pkg::ST_TEST:
                begin
                    TX_STATUS_LAMP <= '{red: 1'b0, green: blink_f};
                    RX_STATUS_LAMP <= '{red: 1'b1, green: 1'b0};
                    RESET_LAMP <= 1'b1;
                    ZONE_LAMP <= {ZONES{2'b10}};
                    DISPLAY <= 12'(BEAMS - 1);
                end
                screen_status_pkg::ST_LATCH:
                begin
                    RX_STATUS_LAMP <= '{red: 1'b1, green: 1'b0};
                    RESET_LAMP <= double_f;
                    ZONE_LAMP <= {ZONES{2'b01}};
                    DISPLAY <= 12'h000;
                end
                screen_status_pkg::ST_CLEAR:
                begin
                    RX_STATUS_LAMP <= '{red: 1'b0,
                        green: cfg_r[`CFG_COARSE_BIT] ? blink_f : 1'b1};
                    RESET_LAMP <= 1'b1;
                    ZONE_LAMP <= {ZONES{2'b01}};
                    DISPLAY <= 12'h000;
                    SAFETY_OUTPUT_PAIR <= 2'h3;
                end
                default:
                begin
                    RX_STATUS_LAMP <= '{red: 1'b1, green: 1'b0};
                    RESET_LAMP <= 1'b1;
                    DISPLAY <= popcount(eff);
                    for (int z = 0; z < ZONES; z++)
                    begin
                        if (BEAM_BLOCKED[0])
                            ZONE_LAMP[z] <= (z == 0) ? 2'b10 : 2'b00;
                        else
                            ZONE_LAMP[z] <= (|eff[z*BPZ +: BPZ]) ? 2'b10 : 2'b01;
                    end
                end
            endcase
        end
    end
    // ----------------------------------------
    // Register read port
    // ----------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            RDATA <= 32'h0;
        else if (RD)
            case (ADDR)
                `OFS_CONFIG: RDATA <= {24'h0, cfg_r};
                `OFS_STATUS: RDATA <= {17'h0, DISPLAY, st_r};
                `OFS_IRQ_STATUS: RDATA <= {28'h0, irq_st_r};
                `OFS_IRQ_ENABLE: RDATA <= {28'h0, irq_en_r};
                default: RDATA <= 32'h0;
            endcase
        else
            RDATA <= 32'h0;
    end
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_FAULT_LOCK: assert property (@(posedge CLK) disable iff (!RESET_N)
        st_r == screen_status_pkg::ST_LOCKOUT |=> RESET_LAMP == 1'b0 && ZONE_LAMP == '0)
        else $error("lockout lamps lit");
    AST_OUT_ONLY_CLEAR: assert property (@(posedge CLK) disable iff (!RESET_N)
        SAFETY_OUTPUT_PAIR != 2'h0 |-> $past(st_r) == screen_status_pkg::ST_CLEAR)
        else $error("outputs on outside clear");
    AST_LATCH_HOLD: assert property (@(posedge CLK) disable iff (!RESET_N)
        st_r == screen_status_pkg::ST_LATCH && !reset_ok && !FAULT && !tst_r
        |=> st_r != screen_status_pkg::ST_CLEAR)
        else $error("latch left without reset");
    AST_BLOCK_RED: assert property (@(posedge CLK) disable iff (!RESET_N)
        st_r == screen_status_pkg::ST_BLOCKED |=> RX_STATUS_LAMP.red && !RX_STATUS_LAMP.green)
        else $error("blocked not red");
    AST_AUTO_CLEAR: assert property (@(posedge CLK) disable iff (!RESET_N)
        st_r == screen_status_pkg::ST_BLOCKED && !any_blk && !FAULT && !tst_r
        && !cfg_r[`CFG_MANUAL_BIT] |=> st_r == screen_status_pkg::ST_CLEAR)
        else $error("auto restart missing");
    AST_TEST_DISP: assert property (@(posedge CLK) disable iff (!RESET_N)
        st_r == screen_status_pkg::ST_TEST |=> DISPLAY == 12'(BEAMS - 1))
        else $error("test display wrong");
    AST_BEAM1: assert property (@(posedge CLK) disable iff (!RESET_N)
        st_r == screen_status_pkg::ST_BLOCKED && BEAM_BLOCKED[0]
        |=> ZONE_LAMP[0] == 2'b10 && DISPLAY == 12'h001)
        else $error("beam one view wrong");
    AST_TX_GREEN: assert property (@(posedge CLK) disable iff (!RESET_N)
        st_r == screen_status_pkg::ST_CLEAR |=> TX_STATUS_LAMP == 2'b01)
        else $error("emitter not green");
endmodule : light_screen_status_logic

// file: tb/screen_partner.sv
// ----------------------------------------
// Operator reset switch and machine control circuit
// ----------------------------------------
module screen_partner (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic press_go,
    input wire logic [7:0] press_cyc,
    input wire logic [1:0] output_pair,
    output logic switch_closed,
    output logic machine_run
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] hold_r;
    // Contact stays closed for the asked span, then opens again
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            hold_r <= 8'h00;
        else if (press_go)
            hold_r <= press_cyc;
        else if (hold_r != 8'h00)
            hold_r <= hold_r - 8'h01;
    end
    // Open contact reads low, so a released switch never echoes the last level
    assign switch_closed = (hold_r != 8'h00);
    // Machine may move only while both channels agree on
    assign machine_run = &output_pair;
endmodule : screen_partner

// file: tb/light_screen_status_logic_tb.sv
`include "screen_status_defines.svh"
module light_screen_status_logic_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BEAMS = 16;
    logic CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic [BEAMS-1:0] BEAM_BLOCKED = 16'h0000;
    logic FAULT = 1'b0;
    logic TEST_OPEN = 1'b0;
    logic RESET_SWITCH;
    logic [7:0] ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [31:0] RDATA;
    screen_status_pkg::lamp_t RX_STATUS_LAMP;
    screen_status_pkg::lamp_t TX_STATUS_LAMP;
    logic RESET_LAMP;
    screen_status_pkg::lamp_t [7:0] ZONE_LAMP;
    logic [11:0] DISPLAY;
    logic [1:0] SAFETY_OUTPUT_PAIR;
    logic IRQ;
    logic press_go = 1'b0;
    logic [7:0] press_cyc = 8'h00;
    logic machine_run;
    logic [4:0] lamps;
    logic [31:0] rd_val;
    int error_cnt = 0;
    int checks_done = 0;
    int cnt;
    // ----------------------------------------
    // Clock, design and partner
    // ----------------------------------------
    always #12.5 CLK = ~CLK;
    // Counts are shortened so a full flash cycle fits in a short window
    light_screen_status_logic #(.FLASH_CYC(4), .SELFTEST_CYC(8), .SHOWCODE_CYC(8),
        .RESET_MIN_CYC(2), .RESET_MAX_CYC(20)) light_screen_status_logic_inst (
        .CLK(CLK), .RESET_N(RESET_N), .BEAM_BLOCKED(BEAM_BLOCKED), .FAULT(FAULT),
        .TEST_OPEN(TEST_OPEN), .RESET_SWITCH(RESET_SWITCH), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .RX_STATUS_LAMP(RX_STATUS_LAMP),
        .TX_STATUS_LAMP(TX_STATUS_LAMP), .RESET_LAMP(RESET_LAMP), .ZONE_LAMP(ZONE_LAMP),
        .DISPLAY(DISPLAY), .SAFETY_OUTPUT_PAIR(SAFETY_OUTPUT_PAIR), .IRQ(IRQ));
    screen_partner screen_partner_inst (.clk(CLK), .rst_n(RESET_N), .press_go(press_go),
        .press_cyc(press_cyc), .output_pair(SAFETY_OUTPUT_PAIR),
        .switch_closed(RESET_SWITCH), .machine_run(machine_run));
    // Lamp bits picked by index in the flash counter
    assign lamps = {RESET_LAMP, TX_STATUS_LAMP.green, TX_STATUS_LAMP.red,
        RX_STATUS_LAMP.green, RX_STATUS_LAMP.red};
    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        rd_val = RDATA;
    endtask : rd
    // Polls the state field under a bound, then lets the lamps catch up
    task automatic wait_state(input logic [2:0] st);
        int n;
        n = 0;
        rd(`OFS_STATUS);
        while (rd_val[2:0] !== st && n < 60)
        begin
            rd(`OFS_STATUS);
            n++;
        end
        check(rd_val[2:0], st);
        repeat (3) @(posedge CLK);
        #1;
    endtask : wait_state
    // Counts lit cycles over two full flash periods
    task automatic wchk(input logic [2:0] sel, input logic [31:0] exp);
        cnt = 0;
        repeat (32)
        begin
            @(posedge CLK);
            #1;
            cnt += lamps[sel];
        end
        if (exp != 32'hFF)
            check(cnt, exp);
        else
            check((cnt > 0 && cnt < 32) ? 32'h1 : 32'h0, 32'h1);
    endtask : wchk
    task automatic press(input logic [7:0] n);
        @(posedge CLK);
        press_cyc <= n;
        press_go <= 1'b1;
        @(posedge CLK);
        press_go <= 1'b0;
        repeat (int'(n) + 10) @(posedge CLK);
    endtask : press
    task automatic set_beams(input logic [BEAMS-1:0] b);
        @(posedge CLK);
        BEAM_BLOCKED <= b;
    endtask : set_beams
    task automatic results;
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        repeat (2) @(posedge CLK);
        RESET_N <= 1'b1;
        rd(`OFS_STATUS);
        check(rd_val[2:0], 3'h0);
        wait_state(3'h1);
        check(DISPLAY, 12'h001);
        rd(`OFS_CONFIG);
        check(rd_val, 32'h00000002);
        wait_state(3'h5);
        check(machine_run, 1'b1);
        check(ZONE_LAMP, 16'h5555);
        wchk(3'h1, 32'h20);
        wchk(3'h4, 32'h20);
        wchk(3'h3, 32'h20);
        // Two beams in zones two and three, auto restart
        set_beams(16'h0024);
        wait_state(3'h6);
        check(DISPLAY, 12'h002);
        check(ZONE_LAMP, 16'h5569);
        check(SAFETY_OUTPUT_PAIR, 2'h0);
        wchk(3'h0, 32'h20);
        wchk(3'h4, 32'h20);
        set_beams(16'h0000);
        wait_state(3'h5);
        check(SAFETY_OUTPUT_PAIR, 2'h3);
        // Sync beam lost: the rest cannot be evaluated
        set_beams(16'h8421);
        wait_state(3'h6);
        check(DISPLAY, 12'h001);
        check(ZONE_LAMP, 16'h0002);
        set_beams(16'h0000);
        wait_state(3'h5);
        wr(`OFS_CONFIG, 32'h0000000A);
        wchk(3'h1, 32'hFF);
        wchk(3'h0, 32'h0);
        wr(`OFS_CONFIG, 32'h00000002);
        // Emitter test input open
        @(posedge CLK);
        TEST_OPEN <= 1'b1;
        wait_state(3'h3);
        check(DISPLAY, 12'(BEAMS - 1));
        check(ZONE_LAMP, 16'hAAAA);
        wchk(3'h3, 32'hFF);
        @(posedge CLK);
        TEST_OPEN <= 1'b0;
        wait_state(3'h5);
        // Manual restart: latch after a block, only a proper press releases it
        wr(`OFS_CONFIG, 32'h00000003);
        set_beams(16'h0010);
        wait_state(3'h6);
        set_beams(16'h0000);
        wait_state(3'h4);
        check(SAFETY_OUTPUT_PAIR, 2'h0);
        check(ZONE_LAMP, 16'h5555);
        wchk(3'h0, 32'h20);
        wchk(3'h4, 32'h10);
        press(8'h19);
        wait_state(3'h4);
        press(8'h01);
        wait_state(3'h4);
        check(machine_run, 1'b0);
        press(8'h06);
        wait_state(3'h5);
        check(machine_run, 1'b1);
        // Interrupts: sticky, masked, enabled, cleared; unmapped place
        rd(`OFS_IRQ_STATUS);
        check(rd_val, 32'h0000000B);
        check(IRQ, 1'b0);
        wr(`OFS_IRQ_ENABLE, 32'h00000001);
        repeat (2) @(posedge CLK);
        #1;
        check(IRQ, 1'b1);
        wr(`OFS_IRQ_CLEAR, 32'h0000000F);
        repeat (2) @(posedge CLK);
        #1;
        check(IRQ, 1'b0);
        rd(`OFS_IRQ_STATUS);
        check(rd_val, 32'h0);
        rd(`OFS_IRQ_ENABLE);
        check(rd_val, 32'h00000001);
        wr(8'h30, 32'hFFFFFFFF);
        rd(8'h30);
        check(rd_val, 32'h0);
        // Internal fault halts everything until power cycles
        @(posedge CLK);
        FAULT <= 1'b1;
        wait_state(3'h2);
        check(SAFETY_OUTPUT_PAIR, 2'h0);
        check(ZONE_LAMP, 16'h0000);
        wchk(3'h0, 32'h08);
        wchk(3'h4, 32'h0);
        wchk(3'h2, 32'h08);
        rd(`OFS_IRQ_STATUS);
        check(rd_val[2], 1'b1);
        @(posedge CLK);
        FAULT <= 1'b0;
        wait_state(3'h2);
        results();
    end
    // Hang guard, far beyond the several hundred cycles the scenarios need
    initial
    begin
        repeat (20000) @(posedge CLK);
        error_cnt++;
        results();
    end
endmodule : light_screen_status_logic_tb
